// ---- inc/lsm_pkg.sv ----
// Package: lane map modes, lane word layout and frame carriers
package lsm_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int MODE_W = 7;
	localparam int SAMP12_W = 12;
	localparam int CPLX_W = 15;
	localparam int LANE_W = 16;
	localparam int LANES_PER_SIDE = 6;
	localparam int BYP_SAMPLES = 16;
	localparam int CPLX_SAMPLES = 4;
	localparam int GROUP_LANES = 3;
	localparam int GROUP_W = 4 * SAMP12_W;
	localparam int BUF_DEPTH = 2;

	// ------------------------------------------------------------
	// Lane map mode codes
	// ------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_19 = 7'h13;
	localparam logic [MODE_W-1:0] MODE_20 = 7'h14;
	localparam logic [MODE_W-1:0] MODE_42 = 7'h2a;
	localparam logic [MODE_W-1:0] MODE_21 = 7'h15;
	localparam logic [MODE_W-1:0] MODE_43 = 7'h2b;
	localparam logic [MODE_W-1:0] MODE_22 = 7'h16;
	localparam logic [MODE_W-1:0] MODE_36 = 7'h24;
	localparam logic [MODE_W-1:0] MODE_23 = 7'h17;
	localparam logic [MODE_W-1:0] MODE_46 = 7'h2e;
	localparam logic [MODE_W-1:0] MODE_24 = 7'h18;
	localparam logic [MODE_W-1:0] MODE_38 = 7'h26;
	localparam logic [MODE_W-1:0] MODE_61 = 7'h3d;
	localparam logic [MODE_W-1:0] MODE_64 = 7'h40;
	localparam logic [MODE_W-1:0] MODE_69 = 7'h45;
	localparam logic [MODE_W-1:0] MODE_71 = 7'h47;

	// Active lanes per side for each complex layout and for bypass
	localparam logic [2:0] DEC8_L2_LANES = 3'h1;
	localparam logic [2:0] DEC_L4_LANES = 3'h2;
	localparam logic [2:0] DEC4_L8_LANES = 3'h4;
	localparam logic [2:0] BYP_LANES = 3'h6;

	// Reset values
	localparam logic MODE_ERR_RST = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MC_NONE,
		MC_BYP_SINGLE,
		MC_BYP_DUAL,
		MC_DEC4_L4,
		MC_DEC4_L8,
		MC_DEC8_L2,
		MC_DEC8_L4
	} lsm_class_t;

	typedef struct packed {
		logic [BYP_SAMPLES-1:0][SAMP12_W-1:0] samp;
		logic [CPLX_SAMPLES-1:0][CPLX_W-1:0] inph;
		logic [CPLX_SAMPLES-1:0][CPLX_W-1:0] quad;
		logic [CPLX_SAMPLES-1:0] inphaseOverrangeFlag;
		logic [CPLX_SAMPLES-1:0] quadratureOverrangeFlag;
	} lsm_frame_t;

	typedef struct packed {
		logic [LANES_PER_SIDE-1:0][LANE_W-1:0] sideALane;
		logic [LANES_PER_SIDE-1:0][LANE_W-1:0] sideBLane;
		logic [LANES_PER_SIDE-1:0] sideAEn;
		logic [LANES_PER_SIDE-1:0] sideBEn;
	} lsm_lanes_t;

endpackage : lsm_pkg

// ---- hdl/lsm_lane_buf.sv ----
// Shift-register buffer between the mapper and the link layer
`timescale 1ns/1ns
module lsm_lane_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);

	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

	// ------------------------------------------------------------
	// Storage and occupancy
	// ------------------------------------------------------------
	// Head always sits in entry 0 so the output is a plain flop
	logic [WIDTH-1:0] memQ [DEPTH];
	logic [WIDTH-1:0] memD [DEPTH];
	logic [CNT_W-1:0] cntQ;
	logic [CNT_W-1:0] cntD;
	logic [CNT_W-1:0] wrIdx;
	logic readyQ;
	logic validQ;
	wire push = inValid & readyQ;
	wire pop = validQ & outReady;

	assign wrIdx = pop ? cntQ - ONE_C : cntQ;
	assign cntD = cntQ + CNT_W'(push) - CNT_W'(pop);

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			wire logic [WIDTH-1:0] shifted;
			if (i == DEPTH - 1) begin : g_last
				assign shifted = pop ? '0 : memQ[i];
			end else begin : g_mid
				assign shifted = pop ? memQ[i+1] : memQ[i];
			end
			assign memD[i] = (push && wrIdx == CNT_W'(i)) ? inData : shifted;
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					memQ[i] <= '0;
				end else begin
					memQ[i] <= memD[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cntQ <= '0;
			readyQ <= 1'b1;
			validQ <= 1'b0;
		end else begin
			cntQ <= cntD;
			readyQ <= cntD < DEPTH_C;
			validQ <= cntD != '0;
		end
	end

	assign inReady = readyQ;
	assign outValid = validQ;
	assign outData = memQ[0];

endmodule : lsm_lane_buf

// ---- hdl/lsm_lane_mapper.sv ----
// Lane sample mapper: places converter samples on side A and B lanes
`timescale 1ns/1ns
module lsm_lane_mapper #(
	parameter int BUF_DEPTH = lsm_pkg::BUF_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [lsm_pkg::MODE_W-1:0] laneMapMode,
	input wire lsm_pkg::lsm_frame_t frameIn,
	input wire logic frameValid,
	output logic frameReady,
	output lsm_pkg::lsm_lanes_t laneOut,
	output logic laneValid,
	input wire logic laneReady,
	output logic modeError
);

	localparam int LW = lsm_pkg::LANE_W;
	localparam int NL = lsm_pkg::LANES_PER_SIDE;
	localparam int GW = lsm_pkg::GROUP_W;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	function automatic lsm_pkg::lsm_class_t classify(
		input logic [lsm_pkg::MODE_W-1:0] m
	);
		lsm_pkg::lsm_class_t c;
		c = lsm_pkg::MC_NONE;
		unique case (m)
			lsm_pkg::MODE_19: c = lsm_pkg::MC_BYP_SINGLE;
			lsm_pkg::MODE_20,
			lsm_pkg::MODE_42: c = lsm_pkg::MC_BYP_DUAL;
			lsm_pkg::MODE_21,
			lsm_pkg::MODE_43: c = lsm_pkg::MC_DEC4_L4;
			lsm_pkg::MODE_22,
			lsm_pkg::MODE_36: c = lsm_pkg::MC_DEC4_L8;
			lsm_pkg::MODE_23,
			lsm_pkg::MODE_46: c = lsm_pkg::MC_DEC8_L2;
			lsm_pkg::MODE_24,
			lsm_pkg::MODE_38,
			lsm_pkg::MODE_61,
			lsm_pkg::MODE_64,
			lsm_pkg::MODE_69,
			lsm_pkg::MODE_71: c = lsm_pkg::MC_DEC8_L4;
			default: c = lsm_pkg::MC_NONE;
		endcase
		return c;
	endfunction : classify

	// The mode is read in the cycle of the frame it applies to, so a mode
	// change between frames lands cleanly on the next accepted frame
	wire lsm_pkg::lsm_class_t modeClass = classify(laneMapMode);
	wire isSingle = modeClass == lsm_pkg::MC_BYP_SINGLE;
	wire isDual = modeClass == lsm_pkg::MC_BYP_DUAL;
	wire isBypass = isSingle | isDual;
	wire isNone = modeClass == lsm_pkg::MC_NONE;

	// One flag per complex layout keeps the lane count select flat
	wire isDec4L4 = modeClass == lsm_pkg::MC_DEC4_L4;
	wire isDec4L8 = modeClass == lsm_pkg::MC_DEC4_L8;
	wire isDec8L2 = modeClass == lsm_pkg::MC_DEC8_L2;
	wire isDec8L4 = modeClass == lsm_pkg::MC_DEC8_L4;
	wire isFourLane = isDec4L4 | isDec8L4;

	// Number of complex lanes used on each side
	logic [2:0] cplxLanes;
	assign cplxLanes =
		isDec8L2 ? lsm_pkg::DEC8_L2_LANES :
		isDec4L8 ? lsm_pkg::DEC4_L8_LANES :
		isFourLane ? lsm_pkg::DEC_L4_LANES :
		3'h0;

	// ------------------------------------------------------------
	// 12-bit bypass packing
	// ------------------------------------------------------------
	// Four samples concatenated MSB first split into three 16-bit words,
	// so the nibble straddles across lanes fall out with no extra muxing
	// The dual layout reuses the same split with a different sample order
	logic [1:0][GW-1:0] grpA;
	logic [1:0][GW-1:0] grpB;
	logic [NL-1:0][LW-1:0] bypA;
	logic [NL-1:0][LW-1:0] bypB;

	genvar g;
	genvar k;
	generate
		for (g = 0; g < 2; g++) begin : g_group
			wire logic [GW-1:0] singA = {
				frameIn.samp[8*g],
				frameIn.samp[8*g+2],
				frameIn.samp[8*g+4],
				frameIn.samp[8*g+6]
			};
			wire logic [GW-1:0] singB = {
				frameIn.samp[8*g+1],
				frameIn.samp[8*g+3],
				frameIn.samp[8*g+5],
				frameIn.samp[8*g+7]
			};
			// Dual channel: A on samp 0..7, B on samp 8..15
			wire logic [GW-1:0] dualA = {
				frameIn.samp[4*g],
				frameIn.samp[4*g+1],
				frameIn.samp[4*g+2],
				frameIn.samp[4*g+3]
			};
			wire logic [GW-1:0] dualB = {
				frameIn.samp[8+4*g],
				frameIn.samp[8+4*g+1],
				frameIn.samp[8+4*g+2],
				frameIn.samp[8+4*g+3]
			};
			assign grpA[g] = isDual ? dualA : singA;
			assign grpB[g] = isDual ? dualB : singB;
			for (k = 0; k < lsm_pkg::GROUP_LANES; k++) begin : g_word
				assign bypA[3*g+k] = grpA[g][GW-1-LW*k -: LW];
				assign bypB[3*g+k] = grpB[g][GW-1-LW*k -: LW];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Complex lane words and lane selection
	// ------------------------------------------------------------
	// Complex words sit on the lowest lanes of each side; the two-lane
	// decimate-by-8 layout carries only sample 0 of each component, so
	// the upstream filter must deliver one complex sample per frame
	lsm_pkg::lsm_lanes_t mapped;

	genvar l;
	generate
		for (l = 0; l < NL; l++) begin : g_lane
			localparam logic [2:0] LIDX = 3'(l);
			wire logic [LW-1:0] cplxA;
			wire logic [LW-1:0] cplxB;
			wire logic useCplx = !isBypass && LIDX < cplxLanes;
			if (l < lsm_pkg::CPLX_SAMPLES) begin : g_cplx
				assign cplxA = {
					frameIn.inph[l],
					frameIn.inphaseOverrangeFlag[l]
				};
				assign cplxB = {
					frameIn.quad[l],
					frameIn.quadratureOverrangeFlag[l]
				};
			end else begin : g_nocplx
				assign cplxA = '0;
				assign cplxB = '0;
			end
			// Lanes a mode leaves unused send zero words
			assign mapped.sideALane[l] = isBypass ? bypA[l] :
				useCplx ? cplxA : '0;
			assign mapped.sideBLane[l] = isBypass ? bypB[l] :
				useCplx ? cplxB : '0;
			assign mapped.sideAEn[l] = isBypass | useCplx;
			assign mapped.sideBEn[l] = isBypass | useCplx;
		end
	endgenerate

	// ------------------------------------------------------------
	// Frame acceptance
	// ------------------------------------------------------------
	// The mapping is a fixed function of mode and frame, with no state
	// carried between frames, so every frame of one mode has the same layout
	logic bufReady;
	wire accept = frameValid & bufReady;
	wire pushValid = frameValid & !isNone;
	// Frames of an unsupported mode are taken and dropped
	// rather than stalled, so a bad mode code cannot wedge the source;
	// modeError marks that the last accepted frame was lost
	logic frameReadyQ;
	logic modeErrQ;

	// Updated only on acceptance so the flag stands until the next frame
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			modeErrQ <= lsm_pkg::MODE_ERR_RST;
		end else if (accept) begin
			modeErrQ <= isNone;
		end
	end

	// Ready mirrors the buffer's own ready flop
	assign frameReadyQ = bufReady;
	assign frameReady = frameReadyQ;
	assign modeError = modeErrQ;

	// ------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------
	// Two entries let the link layer stall for a cycle without losing
	// a frame; ready towards the source is the buffer's registered ready
	lsm_lane_buf #(
		.WIDTH($bits(lsm_pkg::lsm_lanes_t)),
		.DEPTH(BUF_DEPTH)
	// A full buffer takes no frame even when the head leaves that cycle;
	// one bubble keeps frameReady free of any path from laneReady
	) i_lsm_lane_buf (
		.clk_sys(clk_sys),
		.reset(reset),
		.inData(mapped),
		.inValid(pushValid),
		.inReady(bufReady),
		.outData(laneOut),
		.outValid(laneValid),
		.outReady(laneReady)
	);

endmodule : lsm_lane_mapper

// ---- dv/lsm_lane_mapper_asserts.sv ----
// Checker for lane placement and buffer hold of the lane mapper
`timescale 1ns/1ns
module lsm_lane_mapper_chk (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [lsm_pkg::MODE_W-1:0] laneMapMode,
	input wire lsm_pkg::lsm_frame_t frameIn,
	input wire logic frameValid,
	input wire logic frameReady,
	input wire lsm_pkg::lsm_lanes_t laneOut,
	input wire logic laneValid,
	input wire logic laneReady,
	input wire logic modeError
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ----
	// Frame taken into an empty buffer shows at the head next cycle
	// ----
	logic hit;
	logic [6:0] m;
	lsm_pkg::lsm_frame_t f;
	always_ff @(posedge clk_sys) begin
		hit <= !reset && frameValid && frameReady && !laneValid;
		m <= laneMapMode;
		f <= frameIn;
	end
	wire logic s19 = hit && m == lsm_pkg::MODE_19;
	wire logic d2 = hit && m inside {lsm_pkg::MODE_20, lsm_pkg::MODE_42};
	wire logic c4 = hit && m inside {lsm_pkg::MODE_21, lsm_pkg::MODE_43};
	wire logic c8 = hit && m inside {lsm_pkg::MODE_22, lsm_pkg::MODE_36};
	wire logic c2 = hit && m inside {lsm_pkg::MODE_23, lsm_pkg::MODE_46};
	wire logic c4b = hit && m inside {lsm_pkg::MODE_24, lsm_pkg::MODE_38,
		lsm_pkg::MODE_61, lsm_pkg::MODE_64, lsm_pkg::MODE_69, lsm_pkg::MODE_71};
	lanes_m19_a: assert property (
		s19 |-> laneValid && laneOut.sideAEn == 6'h3f && laneOut.sideBEn == 6'h3f)
		else $error("mode 19 enables wrong");
	even_side_a: assert property (
		s19 |-> laneOut.sideALane[0] == {f.samp[0], f.samp[2][11:8]})
		else $error("mode 19 side A lane 0 wrong");
	group_pack_a: assert property (
		s19 |-> laneOut.sideBLane[4] == {f.samp[11][7:0], f.samp[13][11:4]})
		else $error("mode 19 side B lane 4 wrong");
	dual_side_a: assert property (
		d2 |-> laneOut.sideBLane[5] == {f.samp[14][3:0], f.samp[15]})
		else $error("dual side B lane 5 wrong");
	dec4_four_a: assert property (
		c4 |-> laneOut.sideALane[1] == {f.inph[1], f.inphaseOverrangeFlag[1]}
		&& laneOut.sideBEn == 6'h03) else $error("four lane layout wrong");
	dec4_eight_a: assert property (
		c8 |-> laneOut.sideBLane[3] == {f.quad[3], f.quadratureOverrangeFlag[3]}
		&& laneOut.sideAEn == 6'h0f) else $error("eight lane layout wrong");
	dec8_two_a: assert property (
		c2 |-> laneOut.sideALane[0] == {f.inph[0], f.inphaseOverrangeFlag[0]}
		&& laneOut.sideBEn == 6'h01) else $error("two lane layout wrong");
	dec8_four_a: assert property (
		c4b |-> laneOut.sideBLane[1] == {f.quad[1], f.quadratureOverrangeFlag[1]}
		&& laneOut.sideAEn == 6'h03) else $error("dec8 four lane wrong");
	flag_pair_a: assert property (
		c8 |-> laneOut.sideALane[2][0] == f.inphaseOverrangeFlag[2])
		else $error("over-range bit misplaced");
	stall_hold_a: assert property (
		laneValid && !laneReady |=> laneValid && $stable(laneOut))
		else $error("head changed under stall");
	cover property (s19);
	cover property (laneValid && !laneReady && !frameReady);
	cover property (modeError);
endmodule : lsm_lane_mapper_chk

bind lsm_lane_mapper lsm_lane_mapper_chk i_lsm_lane_mapper_chk (
	.clk_sys(clk_sys), .reset(reset), .laneMapMode(laneMapMode),
	.frameIn(frameIn), .frameValid(frameValid), .frameReady(frameReady),
	.laneOut(laneOut), .laneValid(laneValid), .laneReady(laneReady),
	.modeError(modeError));

// ---- dv/lsm_link_rx.sv ----
// Link receiver model: collects lane words, stalls on request
`timescale 1ns/1ns
module lsm_link_rx (
	input wire logic clk_sys,
	input wire logic holdOff,
	input wire lsm_pkg::lsm_lanes_t laneOut,
	input wire logic laneValid,
	output logic laneReady
);
	lsm_pkg::lsm_lanes_t got[$];
	assign laneReady = !holdOff;
	// Words kept whole; the bench compares each against a whole expected word
	always @(posedge clk_sys) begin
		if (laneValid && laneReady) begin
			got.push_back(laneOut);
		end
	end
endmodule : lsm_link_rx

// ---- dv/lsm_lane_mapper_tb.sv ----
// Testbench for the lane mapper with a link receiver model
`timescale 1ns/1ns
module lsm_lane_mapper_tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [6:0] laneMapMode = 7'h00;
	lsm_pkg::lsm_frame_t frameIn = '0;
	logic frameValid = 1'b0;
	logic holdOff = 1'b0;
	logic frameReady, laneValid, laneReady, modeError;
	lsm_pkg::lsm_lanes_t laneOut;
	int err_count = 0;
	int n_checks = 0;
	lsm_lane_mapper i_lsm_lane_mapper (.clk_sys(clk_sys), .reset(reset),
		.laneMapMode(laneMapMode), .frameIn(frameIn), .frameValid(frameValid),
		.frameReady(frameReady), .laneOut(laneOut), .laneValid(laneValid),
		.laneReady(laneReady), .modeError(modeError));
	lsm_link_rx i_lsm_link_rx (.clk_sys(clk_sys), .holdOff(holdOff),
		.laneOut(laneOut), .laneValid(laneValid), .laneReady(laneReady));
	initial forever #20 clk_sys = ~clk_sys;
	// ----
	// Shared helpers
	// ----
	task automatic check(input logic [203:0] s, input logic [203:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	function automatic lsm_pkg::lsm_frame_t mkf(int s);
		lsm_pkg::lsm_frame_t f;
		for (int i = 0; i < 16; i++)
			f.samp[i] = 12'(i * 273 + s * 1031);
		for (int i = 0; i < 4; i++) begin
			f.inph[i] = 15'(i * 4661 + s * 99);
			f.quad[i] = ~f.inph[i];
		end
		f.inphaseOverrangeFlag = 4'(s);
		f.quadratureOverrangeFlag = ~4'(s);
		return f;
	endfunction : mkf
	// n = complex lanes per side, 0 for 12-bit bypass (a, b first, st step)
	function automatic lsm_pkg::lsm_lanes_t expv(lsm_pkg::lsm_frame_t f,
		int n, int a, int b, int st);
		lsm_pkg::lsm_lanes_t e;
		logic [95:0] r, q;
		e = '0;
		if (n == 0) begin
			for (int i = 0; i < 8; i++) begin
				r[95 - 12 * i -: 12] = f.samp[a + st * i];
				q[95 - 12 * i -: 12] = f.samp[b + st * i];
			end
			for (int l = 0; l < 6; l++) begin
				e.sideALane[l] = r[95 - 16 * l -: 16];
				e.sideBLane[l] = q[95 - 16 * l -: 16];
			end
			e.sideAEn = 6'h3f;
			e.sideBEn = 6'h3f;
		end
		for (int l = 0; l < n; l++) begin
			e.sideALane[l] = {f.inph[l], f.inphaseOverrangeFlag[l]};
			e.sideBLane[l] = {f.quad[l], f.quadratureOverrangeFlag[l]};
			e.sideAEn[l] = 1'b1;
			e.sideBEn[l] = 1'b1;
		end
		return e;
	endfunction : expv
	task automatic send(input logic [6:0] m, input lsm_pkg::lsm_frame_t f);
		int n;
		@(negedge clk_sys);
		laneMapMode = m;
		frameIn = f;
		frameValid = 1'b1;
		for (n = 0; n < 50 && frameReady !== 1'b1; n++)
			@(negedge clk_sys);
		if (n == 50) err_count++;
		@(negedge clk_sys);
		frameValid = 1'b0;
	endtask : send
	task automatic expect_word(input lsm_pkg::lsm_lanes_t e);
		int n;
		for (n = 0; n < 50 && i_lsm_link_rx.got.size() == 0; n++)
			@(negedge clk_sys);
		if (n == 50) err_count++;
		else check(i_lsm_link_rx.got.pop_front(), e);
	endtask : expect_word
	// ----
	// Scenarios
	// ----
	task automatic t_single;
		lsm_pkg::lsm_frame_t f;
		f = mkf(1);
		send(lsm_pkg::MODE_19, f);
		expect_word(expv(f, 0, 0, 1, 2));
	endtask : t_single
	task automatic t_dual;
		lsm_pkg::lsm_frame_t f;
		f = mkf(2);
		send(lsm_pkg::MODE_20, f);
		expect_word(expv(f, 0, 0, 8, 1));
		f = mkf(3);
		send(lsm_pkg::MODE_42, f);
		expect_word(expv(f, 0, 0, 8, 1));
	endtask : t_dual
	task automatic t_cplx;
		logic [6:0] md[12] = '{lsm_pkg::MODE_21, lsm_pkg::MODE_43,
			lsm_pkg::MODE_22, lsm_pkg::MODE_36, lsm_pkg::MODE_23, lsm_pkg::MODE_46,
			lsm_pkg::MODE_24, lsm_pkg::MODE_38, lsm_pkg::MODE_61, lsm_pkg::MODE_64,
			lsm_pkg::MODE_69, lsm_pkg::MODE_71};
		int nl[12] = '{2, 2, 4, 4, 1, 1, 2, 2, 2, 2, 2, 2};
		lsm_pkg::lsm_frame_t f;
		for (int k = 0; k < 12; k++) begin
			f = mkf(k + 4);
			send(md[k], f);
			expect_word(expv(f, nl[k], 0, 0, 0));
		end
	endtask : t_cplx
	// Receiver stalls: buffer fills, refuses, then drains in order
	task automatic t_stall;
		lsm_pkg::lsm_frame_t f[3];
		for (int k = 0; k < 3; k++)
			f[k] = mkf(k + 20);
		holdOff = 1'b1;
		send(lsm_pkg::MODE_22, f[0]);
		send(lsm_pkg::MODE_19, f[1]);
		check(204'(frameReady), 204'h0);
		fork
			send(lsm_pkg::MODE_24, f[2]);
			begin
				repeat (4) @(negedge clk_sys);
				holdOff = 1'b0;
			end
		join
		expect_word(expv(f[0], 4, 0, 0, 0));
		expect_word(expv(f[1], 0, 0, 1, 2));
		expect_word(expv(f[2], 2, 0, 0, 0));
	endtask : t_stall
	task automatic t_bad;
		send(7'h00, mkf(30));
		check(204'({modeError, laneValid}), 204'h2);
		send(lsm_pkg::MODE_23, mkf(31));
		expect_word(expv(mkf(31), 1, 0, 0, 0));
		check(204'(modeError), 204'h0);
	endtask : t_bad
	initial begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		check(204'({frameReady, laneValid, modeError}), 204'h4);
		t_single;
		t_dual;
		t_cplx;
		t_stall;
		t_bad;
		report_and_stop;
	end
	// Whole run needs under a hundred cycles
	initial begin
		#400000;
		err_count++;
		report_and_stop;
	end
endmodule : lsm_lane_mapper_tb
